/* File: design/ppc_params.svh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * physical-layer port command and lane diagnostic register bank.
 * Assumes a 32-bit register port in the surrounding switch configuration space.
 */
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

`define PPC_OFS_PORT_CMD      12'h230
`define PPC_OFS_PORT_CTL_SKIP 12'h234
`define PPC_OFS_QUAD0_DIAG    12'h238
`define PPC_OFS_QUAD1_DIAG    12'h23c
`define PPC_OFS_QUAD2_DIAG    12'h240
`define PPC_OFS_PHY_TEST      12'h228

`define PPC_PORT_FIELD_W      4
`define PPC_BIT_LOOPBACK      0
`define PPC_BIT_SCRAMBLE_DIS  1
`define PPC_BIT_RX_L1_ONLY    2
`define PPC_BIT_LB_MASTER     3
`define PPC_PORT_CMD_RW_MASK  32'h00077777

`define PPC_SKIP_LSB          0
`define PPC_SKIP_W            12
`define PPC_SKIP_RESET        12'h49c
`define PPC_SKIP_MIN          12'h49c
`define PPC_SKIP_MAX          12'h602
`define PPC_DISABLE_LSB       16
`define PPC_CRC_CNT_LSB       24

`define PPC_UTP_EN_LSB        28
`define PPC_DIAG_EXP_LSB      0
`define PPC_DIAG_ACT_LSB      8
`define PPC_DIAG_RXDET_LSB    16
`define PPC_DIAG_PRBS_LSB     24

`define PPC_CNT_MAX           8'hff

`endif

/* File: design/ppc_pkg.sv */
/*
 * Types shared by the port command and diagnostic register bank.
 * Assumes the constants header is included where numbers are needed.
 */
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_CFG_IDLE,
    PPC_CFG_LOADING,
    PPC_CFG_DONE
  } ppc_load_state_t;
endpackage

/* File: design/ppc_sat_counter.sv */
/*
 * Saturating event counter with clear, used for the error counts.
 * Assumes the increment input is a single-cycle pulse on clk.
 */
`timescale 1ns/1ps
module ppc_sat_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             incr,
  output logic      [WIDTH-1:0] count
);
  // Count up, hold at full scale, an increment in the same cycle beats clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (incr && count != {WIDTH{1'b1}}) begin
      count <= count + 1'b1;
    end else if (clear && !incr) begin
      count <= '0;
    end
  end
endmodule

/* File: design/ppc_regs.sv */
/*
 * Physical-layer port command, port control, SKIP interval and lane diagnostic
 * registers of a five-port switch, with the per-port controls they drive.
 * Assumes a single-cycle register port (write strobe, read strobe, byte address)
 * and per-port link state machine status and events synchronous to clk.
 */
`timescale 1ns/1ps
`include "ppc_params.svh"
module ppc_regs #(
  parameter int NUM_PORTS = 5,
  parameter int NUM_QUADS = 3,
  parameter int CNT_W     = 8
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire logic [11:0]          regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 eepromLoad,
  input  wire logic                 eepromDone,
  input  wire logic [31:0]          phyTestReg,
  input  wire logic [NUM_PORTS-1:0] linkUp,
  input  wire logic [NUM_PORTS-1:0] inConfigComplete,
  input  wire logic [NUM_PORTS-1:0] inLoopbackMaster,
  input  wire logic [NUM_PORTS-1:0] elecIdleInL0,
  input  wire logic                 port4CrcError,
  input  wire logic [7:0]           utpExpected [NUM_QUADS],
  input  wire logic [7:0]           utpActual   [NUM_QUADS],
  input  wire logic [3:0]           rxDetected  [NUM_QUADS],
  input  wire logic [NUM_QUADS-1:0] prbsError,
  output logic      [31:0]          regRdata,
  output logic                      regRvalid,
  output logic      [NUM_PORTS-1:0] loopbackAllowed,
  output logic      [NUM_PORTS-1:0] scramblerOff,
  output logic      [NUM_PORTS-1:0] enterL0s,
  output logic      [NUM_PORTS-1:0] enterL1,
  output logic      [NUM_PORTS-1:0] trainingDisabled,
  output logic      [11:0]          skipInterval
);

  ppc_pkg::ppc_load_state_t loadState;
  logic [31:0]          portCmd;
  logic [11:0]          skipField;
  logic [NUM_PORTS-1:0] portDisable;
  logic [NUM_PORTS-1:0] lbMaster;
  logic [NUM_PORTS-1:0] eepromScrDis;
  logic [CNT_W-1:0]     port4CrcCount;
  logic [CNT_W-1:0]     prbsCount [NUM_QUADS];
  logic [31:0]          next_rdata;
  logic                 crcClear;
  logic [NUM_QUADS-1:0] prbsClear;

  // Field pick from the per-port command word
  function automatic logic cmdBit(input logic [31:0] w, input int port, input int fld);
    cmdBit = w[port*`PPC_PORT_FIELD_W + fld];
  endfunction

  // Clamp a SKIP interval into its valid window
  function automatic logic [11:0] skipClamp(input logic [11:0] v);
    if (v < `PPC_SKIP_MIN) begin
      skipClamp = `PPC_SKIP_MIN;
    end else if (v > `PPC_SKIP_MAX) begin
      skipClamp = `PPC_SKIP_MAX;
    end else begin
      skipClamp = v;
    end
  endfunction

  // Load sequencing: tracks whether the EEPROM image is being applied
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadState <= ppc_pkg::PPC_CFG_IDLE;
    end else begin
      case (loadState)
        ppc_pkg::PPC_CFG_IDLE:    if (eepromLoad) begin
          loadState <= ppc_pkg::PPC_CFG_LOADING;
        end
        ppc_pkg::PPC_CFG_LOADING: if (eepromDone) begin
          loadState <= ppc_pkg::PPC_CFG_DONE;
        end
        ppc_pkg::PPC_CFG_DONE:    loadState <= ppc_pkg::PPC_CFG_DONE;
        default:                  loadState <= ppc_pkg::PPC_CFG_IDLE;
      endcase
    end
  end

  // Port command writable fields; status and reserved bits kept zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      portCmd <= 32'h0;
    end else if (regWrite && regAddr == `PPC_OFS_PORT_CMD) begin
      portCmd <= regWdata & `PPC_PORT_CMD_RW_MASK;
    end
  end

  // Scrambler disables written during the EEPROM load, per port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eepromScrDis <= '0;
    end else if (regWrite && regAddr == `PPC_OFS_PORT_CMD) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        eepromScrDis[p] <= (loadState == ppc_pkg::PPC_CFG_LOADING) &&
                           regWdata[p*`PPC_PORT_FIELD_W + `PPC_BIT_SCRAMBLE_DIS];
      end
    end
  end

  // Port control and SKIP interval, defaults loaded on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skipField   <= `PPC_SKIP_RESET;
      portDisable <= '0;
    end else if (regWrite && regAddr == `PPC_OFS_PORT_CTL_SKIP) begin
      skipField   <= regWdata[`PPC_SKIP_LSB +: `PPC_SKIP_W];
      portDisable <= regWdata[`PPC_DISABLE_LSB +: NUM_PORTS];
    end
  end

  // Loopback-master status follows the link state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lbMaster <= '0;
    end else begin
      lbMaster <= inLoopbackMaster;
    end
  end

  // Per-port controls toward the link layer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loopbackAllowed  <= '0;
      scramblerOff     <= '0;
      enterL0s         <= '0;
      enterL1          <= '0;
      trainingDisabled <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        loopbackAllowed[p]  <= cmdBit(portCmd, p, `PPC_BIT_LOOPBACK);
        // EEPROM disable waits for config-complete; software disable acts once up
        scramblerOff[p]     <= cmdBit(portCmd, p, `PPC_BIT_SCRAMBLE_DIS) &&
                               (eepromScrDis[p] ? (inConfigComplete[p] || scramblerOff[p])
                                                : linkUp[p]);
        enterL1[p]          <= elecIdleInL0[p] && cmdBit(portCmd, p, `PPC_BIT_RX_L1_ONLY);
        enterL0s[p]         <= elecIdleInL0[p] && !cmdBit(portCmd, p, `PPC_BIT_RX_L1_ONLY);
        trainingDisabled[p] <= portDisable[p];
      end
    end
  end

  // SKIP interval kept inside its valid window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skipInterval <= `PPC_SKIP_RESET;
    end else begin
      skipInterval <= skipClamp(skipField);
    end
  end

  // Error counters, cleared on no read (plain read-only counts)
  assign crcClear  = 1'b0;
  assign prbsClear = '0;

  ppc_sat_counter #(
    .WIDTH (CNT_W)
  ) u_crc_cnt (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (crcClear),
    .incr    (port4CrcError),
    .count   (port4CrcCount)
  );

  for (genvar q = 0; q < NUM_QUADS; q++) begin : g_prbs
    ppc_sat_counter #(
      .WIDTH (CNT_W)
    ) u_prbs_cnt (
      .clk     (clk),
      .reset_n (reset_n),
      .clear   (prbsClear[q]),
      .incr    (prbsError[q]),
      .count   (prbsCount[q])
    );
  end

  // Diagnostic word of one quad; test bytes only while its pattern enable is set
  function automatic logic [31:0] diagWord(input int q);
    logic [31:0] w;
    w = 32'h0;
    if (phyTestReg[`PPC_UTP_EN_LSB + q]) begin
      w[`PPC_DIAG_EXP_LSB +: 8] = utpExpected[q];
      w[`PPC_DIAG_ACT_LSB +: 8] = utpActual[q];
    end
    w[`PPC_DIAG_RXDET_LSB +: 4] = rxDetected[q];
    w[`PPC_DIAG_PRBS_LSB +: 8]  = prbsCount[q];
    diagWord = w;
  endfunction

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0;
    case (regAddr)
      `PPC_OFS_PORT_CMD: begin
        next_rdata = portCmd;
        for (int p = 0; p < NUM_PORTS; p++) begin
          next_rdata[p*`PPC_PORT_FIELD_W + `PPC_BIT_LB_MASTER] = lbMaster[p];
        end
      end
      `PPC_OFS_PORT_CTL_SKIP: begin
        next_rdata[`PPC_SKIP_LSB +: `PPC_SKIP_W]  = skipField;
        next_rdata[`PPC_DISABLE_LSB +: NUM_PORTS] = portDisable;
        next_rdata[`PPC_CRC_CNT_LSB +: 8]         = port4CrcCount;
      end
      `PPC_OFS_QUAD0_DIAG: next_rdata = diagWord(0);
      `PPC_OFS_QUAD1_DIAG: next_rdata = diagWord(1);
      `PPC_OFS_QUAD2_DIAG: next_rdata = diagWord(2);
      default:             next_rdata = 32'h0;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata  <= 32'h0;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= next_rdata;
      end
    end
  end

endmodule

/* File: test/ppc_regs_monitor.sv */
/* Checker of the port command and lane diagnostic bank.
   Bound to ppc_regs; sees only that module's ports. */
`timescale 1ns/1ps
module ppc_regs_monitor #(
  parameter int NUM_PORTS = 5
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 regRead,
  input wire logic [11:0]          regAddr,
  input wire logic [31:0]          regRdata,
  input wire logic                 regRvalid,
  input wire logic [NUM_PORTS-1:0] inLoopbackMaster,
  input wire logic [NUM_PORTS-1:0] elecIdleInL0,
  input wire logic [NUM_PORTS-1:0] enterL0s,
  input wire logic [NUM_PORTS-1:0] enterL1,
  input wire logic [11:0]          skipInterval
);
  // One clock domain, checks idle in reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic mapped;
  // Decode of the five mapped offsets
  assign mapped = regAddr inside {12'h230, 12'h234, 12'h238, 12'h23c, 12'h240};
  chk_skip_clamped: assert property (skipInterval inside {[12'h49c:12'h602]})
    else $error("skip interval outside its valid range");
  chk_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered one cycle later");
  chk_unmapped_zero: assert property (regRead && !mapped |=> regRdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  chk_cmd_reserved: assert property (regRead && regAddr == 12'h230 |=> regRdata[31:20] == 12'h0)
    else $error("command register reserved bits nonzero");
  chk_ctl_reserved: assert property (regRead && regAddr == 12'h234 |=>
    regRdata[23:21] == 3'h0 && regRdata[15:12] == 4'h0) else $error("control register reserved bits nonzero");
  chk_diag_reserved: assert property (regRead && mapped && regAddr >= 12'h238 |=>
    regRdata[23:20] == 4'h0) else $error("diagnostic reserved bits nonzero");
  chk_master_status: assert property (
    regRead && regAddr == 12'h230 && $stable(inLoopbackMaster) |=>
    {regRdata[19], regRdata[15], regRdata[11], regRdata[7], regRdata[3]} == $past(inLoopbackMaster))
    else $error("loopback master status mismatch");
  chk_idle_gating: assert property (((enterL0s | enterL1) & ~$past(elecIdleInL0)) == '0)
    else $error("power state entry without electrical idle");
  // Main scenarios reached
  cover property (regRead && regAddr == 12'h238);
  cover property (|(enterL1 & ~enterL0s));
  cover property (|inLoopbackMaster);
endmodule
bind ppc_regs ppc_regs_monitor #(.NUM_PORTS(NUM_PORTS)) i_mon (.clk, .reset_n, .regRead, .regAddr, .regRdata,
  .regRvalid, .inLoopbackMaster, .elecIdleInL0, .enterL0s, .enterL1, .skipInterval);

/* File: test/ppc_link_partner.sv */
/* Behavioural link state machines of the five ports.
   Assumes the bank's controls are synchronous to clk. */
`timescale 1ns/1ps
module ppc_link_partner #(
  parameter int NUM_PORTS = 5
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 slow,
  input  wire logic                 wantLoop,
  input  wire logic [NUM_PORTS-1:0] loopbackAllowed,
  input  wire logic [NUM_PORTS-1:0] trainingDisabled,
  output logic      [NUM_PORTS-1:0] linkUp,
  output logic      [NUM_PORTS-1:0] inConfigComplete,
  output logic      [NUM_PORTS-1:0] inLoopbackMaster
);
  logic [NUM_PORTS-1:0] training;
  logic [NUM_PORTS-1:0] settled;
  // Training on enabled ports; config-complete rises with link up, a cycle before it when slow; slow adds a cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      training         <= '0;
      settled          <= '0;
      linkUp           <= '0;
      inConfigComplete <= '0;
      inLoopbackMaster <= '0;
    end else begin
      training         <= ~trainingDisabled;
      settled          <= training & ~trainingDisabled;
      linkUp           <= (slow ? settled : training) & ~trainingDisabled;
      inConfigComplete <= training & ~linkUp & ~trainingDisabled;
      inLoopbackMaster <= linkUp & loopbackAllowed & {NUM_PORTS{wantLoop}};
    end
  end
endmodule

/* File: test/tb_top.sv */
/* Self-checking bench of the port command and diagnostic bank.
   Assumes the link partner model drives the link status inputs. */
`timescale 1ns/1ps
module tb_top;
  logic        clk, reset_n, regWrite, regRead, eepromLoad, eepromDone, port4CrcError, slow, wantLoop;
  logic [11:0] regAddr, skipInterval;
  logic [31:0] regWdata, phyTestReg, regRdata, d, s;
  logic [4:0]  linkUp, cfgDone, lbm, elecIdleInL0, loopbackAllowed, scramblerOff, enterL0s, enterL1, trainOff, lb, l1, sc;
  logic [7:0]  utpExpected [3], utpActual [3];
  logic [3:0]  rxDetected [3];
  logic [2:0]  prbsError;
  logic        regRvalid;
  logic [7:0]  pc [3] = '{8'h03, 8'hff, 8'h05};
  logic [11:0] corner [6] = '{12'h000, 12'h49b, 12'h49c, 12'h602, 12'h603, 12'hfff};
  integer      seed = 31, miscompares = 0, tests_run = 0;
  ppc_regs i_dut (.clk, .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .eepromLoad, .eepromDone, .phyTestReg,
    .linkUp, .inConfigComplete(cfgDone), .inLoopbackMaster(lbm), .elecIdleInL0, .port4CrcError, .utpExpected,
    .utpActual, .rxDetected, .prbsError, .regRdata, .regRvalid, .loopbackAllowed, .scramblerOff, .enterL0s, .enterL1,
    .trainingDisabled(trainOff), .skipInterval);
  ppc_link_partner i_partner (.clk, .reset_n, .slow, .wantLoop, .loopbackAllowed, .trainingDisabled(trainOff),
    .linkUp, .inConfigComplete(cfgDone), .inLoopbackMaster(lbm));
  // Status bits of the command register
  function automatic logic [31:0] spread(input logic [4:0] v);
    spread = '0;
    for (int p = 0; p < 5; p++) spread[4*p+3] = v[p];
  endfunction
  // Effective SKIP interval
  function automatic logic [11:0] clamp(input logic [11:0] v);
    clamp = v < 12'h49c ? 12'h49c : (v > 12'h602 ? 12'h602 : v);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRvalid, 1'b1, "read valid");
    chk(regRdata, exp, "read data");
    @(posedge clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  initial begin
    tick(20000);
    miscompares++;
    test_done();
  end
  // Main sequence
  initial begin
    {reset_n, regWrite, regRead, eepromLoad, eepromDone, port4CrcError, slow, prbsError} = '0;
    {regAddr, regWdata, phyTestReg, elecIdleInL0} = '0;
    wantLoop = 1'b1;
    for (int q = 0; q < 3; q++) {utpExpected[q], utpActual[q], rxDetected[q]} = '0;
    tick(5);
    reset_n <= 1'b1;
    rd(12'h230, 32'h0);
    rd(12'h234, 32'h49c);
    for (int q = 0; q < 3; q++) rd(12'h238 + 12'(4 * q), 32'h0);
    rd(12'h22c, 32'h0);
    wr(12'h234, 32'h001f049c);
    tick(8);
    eepromLoad <= 1'b1;
    tick(1);
    eepromLoad <= 1'b0;
    wr(12'h230, 32'h2);
    eepromDone <= 1'b1;
    tick(1);
    eepromDone <= 1'b0;
    tick(8);
    @(negedge clk);
    chk(scramblerOff, 5'h0, "scrambler before config");
    wr(12'h234, 32'h49c);
    tick(8);
    @(negedge clk);
    chk(scramblerOff, 5'h1, "scrambler after config");
    // Loaded disable stays in force when the link drops again
    wr(12'h234, 32'h0001049c);
    tick(8);
    @(negedge clk);
    chk(scramblerOff, 5'h1, "scrambler held after link drop");
    wr(12'h238, 32'hffffffff);
    for (int i = 0; i < 260; i++) begin
      port4CrcError <= 1'b1;
      prbsError <= {i < 5, 1'b1, i < 3};
      for (int q = 0; q < 3; q++) {utpExpected[q], utpActual[q], rxDetected[q]} <= 20'($random(seed));
      tick(1);
    end
    {port4CrcError, prbsError} <= '0;
    for (int q = 0; q < 3; q++) begin
      phyTestReg <= 32'h1 << (28 + q);
      tick(2);
      d = {pc[q], 4'h0, rxDetected[q], utpActual[q], utpExpected[q]};
      rd(12'h238 + 12'(4 * q), d);
      rd(12'h238 + 12'(4 * ((q + 1) % 3)), {pc[(q + 1) % 3], 4'h0, rxDetected[(q + 1) % 3], 16'h0});
    end
    for (int i = 0; i < 24; i++) begin
      d = $random(seed) | 32'h2;
      s = $random(seed);
      if (i < 6) s[11:0] = corner[i];
      wr(12'h230, d);
      slow <= s[31];
      wantLoop <= s[30];
      elecIdleInL0 <= d[28:24];
      wr(12'h234, s);
      tick(8);
      @(negedge clk);
      for (int p = 0; p < 5; p++) {lb[p], l1[p], sc[p]} = {d[4*p], d[4*p+2], d[4*p+1]};
      chk(loopbackAllowed, lb, "loopback permit");
      chk(trainOff, s[20:16], "training disable");
      chk(skipInterval, clamp(s[11:0]), "skip interval");
      chk(enterL0s, d[28:24] & ~l1, "L0s entry");
      chk(enterL1, d[28:24] & l1, "L1 entry");
      chk(scramblerOff, sc & ~s[20:16], "scrambler");
      rd(12'h230, (d & 32'h00077777) | spread(lb & ~s[20:16] & {5{s[30]}}));
      rd(12'h234, {8'hff, 3'h0, s[20:16], 4'h0, s[11:0]});
    end
    test_done();
  end
endmodule
